// >>> verilog/cct_timer.sv
// Overview of operation
// - In wait the timer runs on; its interrupt wakes wait but never halt.
// - Halt freezes counter and registers; interrupt wake resumes, reset restarts.
// - Capture edge during halt arms; on interrupt exit flag sets, counter latched.
// - One interrupt line: flag and enable set and CPU mask clear.
// - Capture interrupt enable requests on either capture flag.
// - Compare interrupt enable requests on either compare flag.
// - Overflow interrupt enable requests on the overflow flag.
// - Outside pulse modes, force bit drives its level bit onto enabled compare pin without match.
// - Compare-two match drives level two on pin two; pin one in modulation mode; neither pin in single-pulse.
// - Compare-one match drives level one onto enabled compare pin one.
// - Edge-select per capture input: 0 falling, 1 rising.
// - Pin enables route pins and gate pin level latching; compare logic and flags keep working.
// - Single-pulse mode: capture-one edge starts pulse, length from compare one.
// - Modulation mode: compare one sets pulse length, compare two sets period.
// - Clock select: 00 div4, 01 div2, 10 div8, 11 external pin.
// - External select without external pin stops the counter.
// - External edge bit picks falling (0) or rising (1) counting transition.
// - Status is read-only, resets to zero, low three bits read zero.
// - Capture flag one sets on edge or modulation period; cleared status-then-low.
// - Compare flags set on equality outside modulation (flag one not in single-pulse either); cleared by status read then low access.
// - Overflow flag sets on wrap; only counter low access clears, not alternate.
// - Capture flag two sets on edge, latching counter; status-then-low clears.
// - Counter resets to FFFC; writing counter low byte resets it too.
// - Modulation compare-two match reloads counter to FFFC.
// - Single-pulse trigger loads FFFC, drives level two, sets flag, captures FFFD.
// - Compare high-byte write inhibits compare until low byte written.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module cct_timer #(
	parameter bit HAS_EXT_PIN = 1'b1
) (
	input  wire logic                      clock,
	input  wire logic                      rst,
	// Register port
	input  wire logic [cct_pkg::CCT_AW-1:0] reg_addr,
	input  wire logic [cct_pkg::CCT_DW-1:0] reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [cct_pkg::CCT_DW-1:0] reg_rdata,
	// CPU state
	input  wire logic                      cpu_wait,
	input  wire logic                      cpu_halt,
	input  wire logic                      cpu_int_mask,
	output logic                           timer_irq,
	// Pins
	input  wire logic                      capture_input_one,
	input  wire logic                      capture_input_two,
	input  wire logic                      external_count_pin,
	output logic                           compare_output_one,
	output logic                           compare_output_one_oe,
	output logic                           compare_output_two,
	output logic                           compare_output_two_oe
);
	import cct_pkg::*;

	function automatic logic edge_seen(input logic cur, input logic prev, input logic rising);
		edge_seen = rising ? (cur & ~prev) : (~cur & prev);
	endfunction : edge_seen

	logic [7:0]  cr1_q,      cr1_d;
	logic [7:0]  cr2_q,      cr2_d;
	logic [15:0] cnt_q,      cnt_d;
	logic [15:0] oc1_q,      oc1_d;
	logic [15:0] oc2_q,      oc2_d;
	logic [15:0] ic1_q,      ic1_d;
	logic [15:0] ic2_q,      ic2_d;
	logic [4:0]  flags_q,    flags_d;
	logic [4:0]  arm_q,      arm_d;
	logic        inh1_q,     inh1_d;
	logic        inh2_q,     inh2_d;
	logic [2:0]  pre_q,      pre_d;
	logic        ext_prev_q, ext_prev_d;
	logic        cap1_prev_q, cap1_prev_d;
	logic        cap2_prev_q, cap2_prev_d;
	logic        halt_arm1_q, halt_arm1_d;
	logic        halt_arm2_q, halt_arm2_d;
	logic        halt_prev_q, halt_prev_d;
	logic        out1_q,     out1_d;
	logic        out2_q,     out2_d;
	logic        irq_q,      irq_d;
	logic [7:0]  rdata_q,    rdata_d;

	cct_clk_sel_t clk_sel;
	logic        pwm_on;
	logic        opm_on;
	logic        pe1;
	logic        pe2;
	logic        lvl1;
	logic        lvl2;
	logic        tick;
	logic        m1;
	logic        m2;
	logic        cap1_edge;
	logic        cap2_edge;
	logic        opm_trig;
	logic        halt_exit;
	logic        cnt_wr;
	logic [4:0]  low_acc;
	logic [4:0]  flag_set;

	assign clk_sel = cct_clk_sel_t'(cr2_q[CCT_C2_CLK_SEL_HI:CCT_C2_CLK_SEL_LO]);
	// Modulation overrides single-pulse when both are set
	assign pwm_on  = cr2_q[CCT_C2_MODULATION];
	assign opm_on  = cr2_q[CCT_C2_SINGLE_PULSE] & ~pwm_on;
	assign pe1     = cr2_q[CCT_C2_PIN_ONE_EN];
	assign pe2     = cr2_q[CCT_C2_PIN_TWO_EN];
	assign lvl1    = cr1_q[CCT_C1_LEVEL_ONE];
	assign lvl2    = cr1_q[CCT_C1_LEVEL_TWO];
	assign halt_exit = halt_prev_q & ~cpu_halt;
	assign cnt_wr  = reg_wr & ((reg_addr == CCT_ADDR_CNT_LOW) | (reg_addr == CCT_ADDR_ALT_LOW));
	assign cap1_edge = edge_seen(capture_input_one, cap1_prev_q,
		cr1_q[CCT_C1_EDGE_ONE]);
	assign cap2_edge = edge_seen(capture_input_two, cap2_prev_q,
		cr2_q[CCT_C2_EDGE_TWO]);
	assign opm_trig  = opm_on & cap1_edge & ~cpu_halt;

	// Timer tick from prescaler or external pin; nothing ticks in halt
	always_comb
	begin
		case (clk_sel)
			CCT_CLK_DIV4: tick = (pre_q[1:0] == 2'b11);
			CCT_CLK_DIV2: tick = pre_q[0];
			CCT_CLK_DIV8: tick = (pre_q == 3'b111);
			CCT_CLK_EXT:  tick = HAS_EXT_PIN & edge_seen(external_count_pin, ext_prev_q,
				cr2_q[CCT_C2_EXT_EDGE]);
			default:      tick = 1'b0;
		endcase
		tick = tick & ~cpu_halt;
	end

	// Full 16-bit compares, gated by the high-byte inhibit
	assign m1 = tick & (cnt_q == oc1_q) & ~inh1_q;
	assign m2 = tick & (cnt_q == oc2_q) & ~inh2_q;

	always_comb
	begin
		low_acc[CCT_F_CAP_ONE] = (reg_rd | reg_wr) & (reg_addr == CCT_ADDR_CAP1_LOW);
		low_acc[CCT_F_CMP_ONE] = (reg_rd | reg_wr) & (reg_addr == CCT_ADDR_CMP1_LOW);
		low_acc[CCT_F_OVF]     = (reg_rd | reg_wr) & (reg_addr == CCT_ADDR_CNT_LOW);
		low_acc[CCT_F_CAP_TWO] = (reg_rd | reg_wr) & (reg_addr == CCT_ADDR_CAP2_LOW);
		low_acc[CCT_F_CMP_TWO] = (reg_rd | reg_wr) & (reg_addr == CCT_ADDR_CMP2_LOW);
		flag_set[CCT_F_CAP_ONE] = (cap1_edge & ~opm_on & ~pwm_on & ~cpu_halt)
			| (halt_exit & halt_arm1_q) | (pwm_on & m2) | opm_trig;
		flag_set[CCT_F_CMP_ONE] = m1 & ~opm_on & ~pwm_on;
		flag_set[CCT_F_OVF]     = tick & (cnt_q == CCT_CNT_MAX) & ~(pwm_on & m2);
		flag_set[CCT_F_CAP_TWO] = (cap2_edge & ~cpu_halt) | (halt_exit & halt_arm2_q);
		flag_set[CCT_F_CMP_TWO] = m2 & ~pwm_on;
	end

	// Next-state logic for the whole timer
	always_comb
	begin
		cr1_d       = cr1_q;
		cr2_d       = cr2_q;
		oc1_d       = oc1_q;
		oc2_d       = oc2_q;
		ic1_d       = ic1_q;
		ic2_d       = ic2_q;
		inh1_d      = inh1_q;
		inh2_d      = inh2_q;
		out1_d      = out1_q;
		out2_d      = out2_q;
		pre_d       = cpu_halt ? pre_q : pre_q + 3'h1;
		ext_prev_d  = external_count_pin;
		cap1_prev_d = capture_input_one;
		cap2_prev_d = capture_input_two;
		halt_prev_d = cpu_halt;
		halt_arm1_d = halt_arm1_q;
		halt_arm2_d = halt_arm2_q;

		// Software writes
		if (reg_wr)
		begin
			case (reg_addr)
				CCT_ADDR_CTRL_ONE: cr1_d = reg_wdata;
				CCT_ADDR_CTRL_TWO: cr2_d = reg_wdata;
				CCT_ADDR_CMP1_HIGH:
				begin
					oc1_d[15:8] = reg_wdata;
					inh1_d      = 1'b1;
				end
				CCT_ADDR_CMP1_LOW:
				begin
					oc1_d[7:0] = reg_wdata;
					inh1_d     = 1'b0;
				end
				CCT_ADDR_CMP2_HIGH:
				begin
					oc2_d[15:8] = reg_wdata;
					inh2_d      = 1'b1;
				end
				CCT_ADDR_CMP2_LOW:
				begin
					oc2_d[7:0] = reg_wdata;
					inh2_d     = 1'b0;
				end
				default: ;
			endcase
		end

		// Counter: software reset, period reloads, then ticks
		if (cnt_wr)
			cnt_d = CCT_CNT_RESET;
		else if (pwm_on & m2)
			cnt_d = CCT_CNT_RESET;
		else if (opm_trig)
			cnt_d = CCT_CNT_RESET;
		else if (tick)
			cnt_d = cnt_q + 16'h0001;
		else
			cnt_d = cnt_q;

		// Captures; edges in halt only arm until the wake
		if (opm_trig)
			ic1_d = CCT_PULSE_CAPTURE;
		else if (cap1_edge & ~opm_on & ~pwm_on)
		begin
			if (cpu_halt)
				halt_arm1_d = 1'b1;
			else
				ic1_d = cnt_q;
		end
		if (halt_exit & halt_arm1_q)
		begin
			ic1_d       = cnt_q;
			halt_arm1_d = 1'b0;
		end
		if (cap2_edge)
		begin
			if (cpu_halt)
				halt_arm2_d = 1'b1;
			else
				ic2_d = cnt_q;
		end
		if (halt_exit & halt_arm2_q)
		begin
			ic2_d       = cnt_q;
			halt_arm2_d = 1'b0;
		end

		// Compare pin levels, latched only while the pin is enabled
		if (pwm_on)
		begin
			if (pe1 & m2)
				out1_d = lvl2;
			else if (pe1 & m1)
				out1_d = lvl1;
		end
		else if (opm_on)
		begin
			if (pe1 & opm_trig)
				out1_d = lvl2;
			else if (pe1 & m1)
				out1_d = lvl1;
		end
		else
		begin
			if (pe1 & (cr1_q[CCT_C1_FORCE_ONE] | m1))
				out1_d = lvl1;
			if (pe2 & (cr1_q[CCT_C1_FORCE_TWO] | m2))
				out2_d = lvl2;
		end

		// Flags: status read arms the clear, low-byte access clears, set wins
		arm_d   = (reg_rd & (reg_addr == CCT_ADDR_STATUS)) ? flags_q : (arm_q & ~low_acc);
		flags_d = flag_set | (flags_q & ~(arm_q & low_acc));

		// One shared request; never raised in halt
		irq_d = ~cpu_int_mask & ~cpu_halt & (
			(cr1_q[CCT_C1_CAP_IE] & (flags_q[CCT_F_CAP_ONE] | flags_q[CCT_F_CAP_TWO]))
			| (cr1_q[CCT_C1_CMP_IE] & (flags_q[CCT_F_CMP_ONE] | flags_q[CCT_F_CMP_TWO]))
			| (cr1_q[CCT_C1_OVF_IE] & flags_q[CCT_F_OVF]));

		// Read data, valid the cycle after the strobe
		rdata_d = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				CCT_ADDR_CTRL_ONE:  rdata_d = cr1_q;
				CCT_ADDR_CTRL_TWO:  rdata_d = cr2_q;
				CCT_ADDR_STATUS:    rdata_d = {flags_q, 3'b000};
				CCT_ADDR_CAP1_HIGH: rdata_d = ic1_q[15:8];
				CCT_ADDR_CAP1_LOW:  rdata_d = ic1_q[7:0];
				CCT_ADDR_CMP1_HIGH: rdata_d = oc1_q[15:8];
				CCT_ADDR_CMP1_LOW:  rdata_d = oc1_q[7:0];
				CCT_ADDR_CNT_HIGH:  rdata_d = cnt_q[15:8];
				CCT_ADDR_CNT_LOW:   rdata_d = cnt_q[7:0];
				CCT_ADDR_ALT_HIGH:  rdata_d = cnt_q[15:8];
				CCT_ADDR_ALT_LOW:   rdata_d = cnt_q[7:0];
				CCT_ADDR_CMP2_HIGH: rdata_d = oc2_q[15:8];
				CCT_ADDR_CMP2_LOW:  rdata_d = oc2_q[7:0];
				CCT_ADDR_CAP2_HIGH: rdata_d = ic2_q[15:8];
				CCT_ADDR_CAP2_LOW:  rdata_d = ic2_q[7:0];
				default:            rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cr1_q       <= CCT_CTRL_RESET;
			cr2_q       <= CCT_CTRL_RESET;
			cnt_q       <= CCT_CNT_RESET;
			oc1_q       <= {CCT_CMP_HIGH_RESET, CCT_CMP_LOW_RESET};
			oc2_q       <= {CCT_CMP_HIGH_RESET, CCT_CMP_LOW_RESET};
			ic1_q       <= 16'h0000;
			ic2_q       <= 16'h0000;
			flags_q     <= 5'h00;
			arm_q       <= 5'h00;
			inh1_q      <= 1'b0;
			inh2_q      <= 1'b0;
			pre_q       <= 3'h0;
			ext_prev_q  <= 1'b0;
			cap1_prev_q <= 1'b0;
			cap2_prev_q <= 1'b0;
			halt_arm1_q <= 1'b0;
			halt_arm2_q <= 1'b0;
			halt_prev_q <= 1'b0;
			out1_q      <= 1'b0;
			out2_q      <= 1'b0;
			irq_q       <= 1'b0;
			rdata_q     <= 8'h00;
		end
		else
		begin
			cr1_q       <= cr1_d;
			cr2_q       <= cr2_d;
			cnt_q       <= cnt_d;
			oc1_q       <= oc1_d;
			oc2_q       <= oc2_d;
			ic1_q       <= ic1_d;
			ic2_q       <= ic2_d;
			flags_q     <= flags_d;
			arm_q       <= arm_d;
			inh1_q      <= inh1_d;
			inh2_q      <= inh2_d;
			pre_q       <= pre_d;
			ext_prev_q  <= ext_prev_d;
			cap1_prev_q <= cap1_prev_d;
			cap2_prev_q <= cap2_prev_d;
			halt_arm1_q <= halt_arm1_d;
			halt_arm2_q <= halt_arm2_d;
			halt_prev_q <= halt_prev_d;
			out1_q      <= out1_d;
			out2_q      <= out2_d;
			irq_q       <= irq_d;
			rdata_q     <= rdata_d;
		end
	end

	assign reg_rdata             = rdata_q;
	assign timer_irq             = irq_q;
	assign compare_output_one    = out1_q;
	assign compare_output_two    = out2_q;
	// Pin enables steer the pins and also gate their level latches
	assign compare_output_one_oe = pe1;
	assign compare_output_two_oe = pe2;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_status_read_cmp1;
		reg_rd && (reg_addr == CCT_ADDR_STATUS) && flags_q[CCT_F_CMP_ONE];
	endsequence
	sequence s_cmp1_low_access;
		(reg_rd || reg_wr) && (reg_addr == CCT_ADDR_CMP1_LOW) && !flag_set[CCT_F_CMP_ONE];
	endsequence

	property p_halt_freeze;
		(cpu_halt && !cnt_wr) |=> (cnt_q == $past(cnt_q));
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved in halt");

	property p_halt_no_irq;
		cpu_halt |=> !timer_irq;
	endproperty
	a_halt_no_irq: assert property (p_halt_no_irq) else $error("irq raised in halt");

	property p_mask_blocks;
		cpu_int_mask |=> !timer_irq;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("irq despite mask");

	property p_cnt_low_write;
		cnt_wr |=> (cnt_q == CCT_CNT_RESET);
	endproperty
	a_cnt_low_write: assert property (p_cnt_low_write) else $error("counter not reset");

	property p_overflow_set;
		(tick && cnt_q == CCT_CNT_MAX && !pwm_on && !cnt_wr && !opm_trig)
			|=> (flags_q[CCT_F_OVF] && cnt_q == 16'h0000);
	endproperty
	a_overflow_set: assert property (p_overflow_set) else $error("overflow missed");

	property p_status_low_zero;
		(reg_rd && reg_addr == CCT_ADDR_STATUS) |=> (reg_rdata[2:0] == 3'b000);
	endproperty
	a_status_low_zero: assert property (p_status_low_zero) else $error("status low bits");

	property p_cmp1_clear;
		s_status_read_cmp1 ##1 s_cmp1_low_access |=> !flags_q[CCT_F_CMP_ONE];
	endproperty
	a_cmp1_clear: assert property (p_cmp1_clear) else $error("compare flag not cleared");

	property p_no_ext_pin_stop;
		(!HAS_EXT_PIN && clk_sel == CCT_CLK_EXT && !cnt_wr && !opm_trig) |=> $stable(cnt_q);
	endproperty
	a_no_ext_pin_stop: assert property (p_no_ext_pin_stop) else $error("counter ran");

	property p_pwm_reload;
		(pwm_on && m2 && !cnt_wr) |=> (cnt_q == CCT_CNT_RESET && flags_q[CCT_F_CAP_ONE]);
	endproperty
	a_pwm_reload: assert property (p_pwm_reload) else $error("period reload missed");

	property p_pulse_trigger;
		(opm_trig && pe1 && !cnt_wr)
			|=> (ic1_q == CCT_PULSE_CAPTURE && cnt_q == CCT_CNT_RESET && out1_q == $past(lvl2));
	endproperty
	a_pulse_trigger: assert property (p_pulse_trigger) else $error("pulse start wrong");

	property p_inhibit;
		(reg_wr && reg_addr == CCT_ADDR_CMP1_HIGH) |=> !m1 until (reg_wr && reg_addr == CCT_ADDR_CMP1_LOW);
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("compare not inhibited");

	property p_div2_spacing;
		(clk_sel == CCT_CLK_DIV2 && tick) |=> !tick;
	endproperty
	a_div2_spacing: assert property (p_div2_spacing) else $error("div2 tick spacing");
endmodule : cct_timer

// >>> verilog/cct_pkg.sv
package cct_pkg;
	localparam int          CCT_AW               = 4;
	localparam int          CCT_DW               = 8;
	// Register map (byte-wide registers, one per address)
	localparam logic [3:0]  CCT_ADDR_CTRL_TWO    = 4'h0;
	localparam logic [3:0]  CCT_ADDR_CTRL_ONE    = 4'h1;
	localparam logic [3:0]  CCT_ADDR_STATUS      = 4'h2;
	localparam logic [3:0]  CCT_ADDR_CAP1_HIGH   = 4'h3;
	localparam logic [3:0]  CCT_ADDR_CAP1_LOW    = 4'h4;
	localparam logic [3:0]  CCT_ADDR_CMP1_HIGH   = 4'h5;
	localparam logic [3:0]  CCT_ADDR_CMP1_LOW    = 4'h6;
	localparam logic [3:0]  CCT_ADDR_CNT_HIGH    = 4'h7;
	localparam logic [3:0]  CCT_ADDR_CNT_LOW     = 4'h8;
	localparam logic [3:0]  CCT_ADDR_ALT_HIGH    = 4'h9;
	localparam logic [3:0]  CCT_ADDR_ALT_LOW     = 4'hA;
	localparam logic [3:0]  CCT_ADDR_CMP2_HIGH   = 4'hB;
	localparam logic [3:0]  CCT_ADDR_CMP2_LOW    = 4'hC;
	localparam logic [3:0]  CCT_ADDR_CAP2_HIGH   = 4'hD;
	localparam logic [3:0]  CCT_ADDR_CAP2_LOW    = 4'hE;
	// Control one fields
	localparam int          CCT_C1_CAP_IE        = 7;
	localparam int          CCT_C1_CMP_IE        = 6;
	localparam int          CCT_C1_OVF_IE        = 5;
	localparam int          CCT_C1_FORCE_TWO     = 4;
	localparam int          CCT_C1_FORCE_ONE     = 3;
	localparam int          CCT_C1_LEVEL_TWO     = 2;
	localparam int          CCT_C1_EDGE_ONE      = 1;
	localparam int          CCT_C1_LEVEL_ONE     = 0;
	// Control two fields
	localparam int          CCT_C2_PIN_ONE_EN    = 7;
	localparam int          CCT_C2_PIN_TWO_EN    = 6;
	localparam int          CCT_C2_SINGLE_PULSE  = 5;
	localparam int          CCT_C2_MODULATION    = 4;
	localparam int          CCT_C2_CLK_SEL_HI    = 3;
	localparam int          CCT_C2_CLK_SEL_LO    = 2;
	localparam int          CCT_C2_EDGE_TWO      = 1;
	localparam int          CCT_C2_EXT_EDGE      = 0;
	// Flag vector positions; status bits 7:3 carry the vector, 2:0 read zero
	localparam int          CCT_F_CAP_ONE        = 4;
	localparam int          CCT_F_CMP_ONE        = 3;
	localparam int          CCT_F_OVF            = 2;
	localparam int          CCT_F_CAP_TWO        = 1;
	localparam int          CCT_F_CMP_TWO        = 0;
	// Reset and reload values
	localparam logic [7:0]  CCT_CTRL_RESET       = 8'h00;
	localparam logic [7:0]  CCT_CMP_HIGH_RESET   = 8'h80;
	localparam logic [7:0]  CCT_CMP_LOW_RESET    = 8'h00;
	localparam logic [15:0] CCT_CNT_RESET        = 16'hFFFC;
	localparam logic [15:0] CCT_PULSE_CAPTURE    = 16'hFFFD;
	localparam logic [15:0] CCT_CNT_MAX          = 16'hFFFF;

	typedef enum logic [1:0] {
		CCT_CLK_DIV4 = 2'b00,
		CCT_CLK_DIV2 = 2'b01,
		CCT_CLK_DIV8 = 2'b10,
		CCT_CLK_EXT  = 2'b11
	} cct_clk_sel_t;
endpackage : cct_pkg

// >>> tb/cct_pin_model.sv
`timescale 1ns/1ps
module cct_pin_model (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Requests from the bench
	input  wire logic cap_one_cmd,
	input  wire logic cap_two_cmd,
	// Pins toward the timer
	output logic      capture_input_one,
	output logic      capture_input_two,
	output logic      external_count_pin
);
	logic [2:0] div_q;
	logic [2:0] div_d;

	always_comb
	begin
		div_d = div_q + 3'h1;
	end

	// Free-running count clock, one period every eight cycles
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			div_q              <= 3'h0;
			capture_input_one  <= 1'b0;
			capture_input_two  <= 1'b0;
			external_count_pin <= 1'b0;
		end
		else
		begin
			div_q              <= div_d;
			capture_input_one  <= cap_one_cmd;
			capture_input_two  <= cap_two_cmd;
			external_count_pin <= div_q[2];
		end
	end
endmodule : cct_pin_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import cct_pkg::*;
	typedef struct {logic [3:0] a; logic [7:0] e; logic [7:0] m;} cct_note_t;
	logic       clock, rst, reg_wr, reg_rd, cpu_wait, cpu_halt, cpu_int_mask, timer_irq;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rnd;
	logic       cap_one_cmd, cap_two_cmd, cap1, cap2, ext_pin, out1, oe1, out2, oe2;
	logic       rd_seen = 1'b0;
	cct_note_t  exp_q[$];
	cct_note_t  note;
	int         bad_count, n_tests;
	logic [15:0] lfsr;

	cct_timer uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_wait(cpu_wait),
		.cpu_halt(cpu_halt), .cpu_int_mask(cpu_int_mask), .timer_irq(timer_irq),
		.capture_input_one(cap1), .capture_input_two(cap2), .external_count_pin(ext_pin),
		.compare_output_one(out1), .compare_output_one_oe(oe1),
		.compare_output_two(out2), .compare_output_two_oe(oe2));
	cct_pin_model pins (.clock(clock), .rst(rst), .cap_one_cmd(cap_one_cmd),
		.cap_two_cmd(cap_two_cmd), .capture_input_one(cap1), .capture_input_two(cap2),
		.external_count_pin(ext_pin));

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic tally_and_finish;
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wait_for(input string nm, ref logic s, input logic e, input int bound);
		int i;
		for (i = 0; i < bound && s !== e; i++)
			@(negedge clock);
		chk(nm, {7'h0, e}, {7'h0, s});
		if (s !== e)
			tally_and_finish();
	endtask : wait_for

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		exp_q.push_back('{a, e, m});
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask : rd

	// Read data stand in the cycle after the read edge only
	always @(posedge clock)
	begin
		if (rd_seen === 1'b1)
		begin
			note = exp_q.pop_front();
			chk($sformatf("reg %h", note.a), note.e, reg_rdata & note.m);
		end
		rd_seen <= reg_rd;
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		bad_count++;
		tally_and_finish();
	end

	initial
	begin
		{reg_wr, reg_rd, cpu_wait, cpu_halt, cpu_int_mask, cap_one_cmd, cap_two_cmd} = 7'h0;
		{reg_addr, reg_wdata, bad_count, n_tests} = '0;
		lfsr = 16'd10717;
		rst  = 1'b1;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rd(CCT_ADDR_CNT_LOW, 8'hFC, 8'hFE);
		rd(CCT_ADDR_CNT_HIGH, 8'hFF, 8'hFF);
		rd(CCT_ADDR_STATUS, 8'h00, 8'hFF);
		rd(CCT_ADDR_CTRL_ONE, 8'h00, 8'hFF);
		rd(CCT_ADDR_CTRL_TWO, 8'h00, 8'hFF);
		rd(CCT_ADDR_CMP1_HIGH, 8'h80, 8'hFF);
		rd(CCT_ADDR_CMP1_LOW, 8'h00, 8'hFF);
		rd(CCT_ADDR_CMP2_HIGH, 8'h80, 8'hFF);
		rd(4'hF, 8'h00, 8'hFF);
		wr(CCT_ADDR_STATUS, 8'hFF);
		rd(CCT_ADDR_STATUS, 8'h00, 8'h07);
		for (int k = 0; k < 4; k++)
		begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			rnd  = lfsr[7:0];
			wr(k[0] ? CCT_ADDR_CTRL_TWO : CCT_ADDR_CTRL_ONE, rnd);
			rd(k[0] ? CCT_ADDR_CTRL_TWO : CCT_ADDR_CTRL_ONE, rnd, 8'hFF);
		end
		wr(CCT_ADDR_CTRL_ONE, 8'h00);
		// Counter rate per clock select, coarse window on the low byte
		for (int s = 0; s < 4; s++)
		begin
			wr(CCT_ADDR_CTRL_TWO, {4'h0, s[1:0], 2'b01});
			wr(CCT_ADDR_CNT_LOW, 8'h00);
			repeat (128) @(posedge clock);
			rd(CCT_ADDR_CNT_LOW, s == 0 ? 8'h10 : s == 1 ? 8'h30 : 8'h00, 8'hF0);
		end
		rd(CCT_ADDR_STATUS, 8'h20, 8'h20);
		rd(CCT_ADDR_CNT_LOW, 8'h00, 8'h00);
		// Overflow interrupt while the CPU waits
		wr(CCT_ADDR_CTRL_TWO, 8'h04);
		wr(CCT_ADDR_CTRL_ONE, 8'h20);
		cpu_wait <= 1'b1;
		wr(CCT_ADDR_CNT_LOW, 8'h00);
		wait_for("timer_irq", timer_irq, 1'b1, 100);
		cpu_wait <= 1'b0;
		rd(CCT_ADDR_STATUS, 8'h20, 8'hFF);
		rd(CCT_ADDR_ALT_LOW, 8'h00, 8'h00);
		rd(CCT_ADDR_STATUS, 8'h20, 8'hFF);
		rd(CCT_ADDR_CNT_LOW, 8'h00, 8'h00);
		rd(CCT_ADDR_STATUS, 8'h00, 8'hFF);
		wait_for("timer_irq", timer_irq, 1'b0, 5);
		// Compare one match; compare two held off by a lone high write
		wr(CCT_ADDR_CMP2_HIGH, 8'h00);
		wr(CCT_ADDR_CTRL_ONE, 8'h41);
		wr(CCT_ADDR_CTRL_TWO, 8'h84);
		wr(CCT_ADDR_CNT_LOW, 8'h00);
		wr(CCT_ADDR_CMP1_HIGH, 8'h00);
		wr(CCT_ADDR_CMP1_LOW, 8'h20);
		wait_for("timer_irq", timer_irq, 1'b1, 200);
		wait_for("out_one", out1, 1'b1, 3);
		wait_for("oe_one", oe1, 1'b1, 1);
		rd(CCT_ADDR_STATUS, 8'h60, 8'hFF);
		cpu_int_mask <= 1'b1;
		repeat (3) @(posedge clock);
		wait_for("timer_irq", timer_irq, 1'b0, 1);
		cpu_int_mask <= 1'b0;
		rd(CCT_ADDR_CMP1_LOW, 8'h20, 8'hFF);
		rd(CCT_ADDR_STATUS, 8'h20, 8'hFF);
		// Forced level on pin two
		wr(CCT_ADDR_CTRL_ONE, 8'h14);
		wr(CCT_ADDR_CTRL_TWO, 8'h44);
		wait_for("out_two", out2, 1'b1, 4);
		wr(CCT_ADDR_CTRL_ONE, 8'h10);
		wait_for("out_two", out2, 1'b0, 4);
		// Capture two on falling edges only
		wr(CCT_ADDR_CTRL_ONE, 8'h00);
		wr(CCT_ADDR_CTRL_TWO, 8'h04);
		cap_two_cmd <= 1'b1;
		repeat (4) @(posedge clock);
		rd(CCT_ADDR_STATUS, 8'h00, 8'h10);
		cap_two_cmd <= 1'b0;
		repeat (4) @(posedge clock);
		rd(CCT_ADDR_STATUS, 8'h10, 8'h10);
		rd(CCT_ADDR_CAP2_LOW, 8'h00, 8'h00);
		rd(CCT_ADDR_STATUS, 8'h00, 8'h10);
		// Capture edge during halt is held until halt ends
		wr(CCT_ADDR_CTRL_ONE, 8'h82);
		cpu_halt <= 1'b1;
		repeat (2) @(posedge clock);
		cap_one_cmd <= 1'b1;
		repeat (6) @(posedge clock);
		wait_for("timer_irq", timer_irq, 1'b0, 1);
		cpu_halt <= 1'b0;
		wait_for("timer_irq", timer_irq, 1'b1, 10);
		rd(CCT_ADDR_STATUS, 8'h80, 8'h80);
		rd(CCT_ADDR_CAP1_LOW, 8'h00, 8'h00);
		// Single pulse from a rising capture-one edge
		cap_one_cmd <= 1'b0;
		wr(CCT_ADDR_CTRL_TWO, 8'h84);
		wr(CCT_ADDR_CTRL_ONE, 8'h0E);
		wait_for("out_one", out1, 1'b0, 4);
		wr(CCT_ADDR_CMP1_HIGH, 8'h00);
		wr(CCT_ADDR_CMP1_LOW, 8'h40);
		wr(CCT_ADDR_CTRL_ONE, 8'h06);
		wr(CCT_ADDR_CTRL_TWO, 8'hA4);
		cap_one_cmd <= 1'b1;
		wait_for("out_one", out1, 1'b1, 6);
		rd(CCT_ADDR_CAP1_HIGH, 8'hFF, 8'hFF);
		rd(CCT_ADDR_CAP1_LOW, 8'hFD, 8'hFF);
		rd(CCT_ADDR_STATUS, 8'h80, 8'h80);
		wait_for("out_one", out1, 1'b0, 300);
		rd(CCT_ADDR_CAP1_LOW, 8'hFD, 8'hFF);
		rd(CCT_ADDR_STATUS, 8'h00, 8'h80);
		// Modulation: compare two sets period, compare one ends the pulse
		wr(CCT_ADDR_CMP1_LOW, 8'h10);
		wr(CCT_ADDR_CMP2_HIGH, 8'h00);
		wr(CCT_ADDR_CMP2_LOW, 8'h20);
		wr(CCT_ADDR_CTRL_ONE, 8'h04);
		wr(CCT_ADDR_CTRL_TWO, 8'h94);
		wr(CCT_ADDR_CNT_LOW, 8'h00);
		wait_for("out_one", out1, 1'b1, 200);
		wait_for("out_one", out1, 1'b0, 100);
		rd(CCT_ADDR_STATUS, 8'h80, 8'hC8);
		repeat (3) @(posedge clock);
		tally_and_finish();
	end
endmodule : tb_top
